// ==== shared/hfx_regs.svh ====
// Register indices, field positions, reset values and sizes of the frame FIFO block.
// Assumes a 32-bit bus whose byte address is four times the register index.
`ifndef HFX_REGS_SVH
`define HFX_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------------------------------------------
`define HFX_IDX_EVENTS     6'h20
`define HFX_IDX_STATUS     6'h21
`define HFX_IDX_MODE       6'h22
`define HFX_IDX_EXT_IRQ    6'h24
`define HFX_IDX_RX_CNT_LO  6'h25
`define HFX_IDX_RX_STAT    6'h27
`define HFX_IDX_TX_CNT_LO  6'h2a
`define HFX_IDX_CNT_HI     6'h2d
`define HFX_IDX_CFG_ONE    6'h2f

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define HFX_CMD_TX_RESET   0
`define HFX_CMD_END_MSG    1
`define HFX_CMD_TX_IFRAME  2
`define HFX_CMD_TX_TRANSP  3
`define HFX_CMD_RX_RESET   6
`define HFX_CMD_RX_DONE    7
`define HFX_EVT_MSG_END    7
`define HFX_EVT_POOL_FULL  6
`define HFX_EVT_POOL_READY 4
`define HFX_EXT_UNDERRUN   6
`define HFX_STS_TX_WR_EN   6
`define HFX_STS_RX_IDLE    3
`define HFX_STS_TX_BUSY    2
`define HFX_MODE_RX_ACTIVE 3
`define HFX_HI_DMA         7
`define HFX_CFG_POWER_UP   7
`define HFX_RXSTAT_OVFL    5

// ----------------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------------
`define HFX_RST_BYTE       8'h00
`define HFX_FIFO_DEPTH     64
`define HFX_POOL_BYTES     32

`endif

// ==== shared/hfx_pkg.sv ====
// Types shared by the frame FIFO block and its memory.
// Assumes the constants of hfx_regs.svh.
package hfx_pkg;
   typedef logic [7:0] hfx_byte_t;
   typedef enum logic [1:0] {
      HFX_TX_IDLE = 2'b01,
      HFX_TX_SEND = 2'b10
   } hfx_tx_e;
endpackage

// ==== logic/hfx_mem.sv ====
// Byte memory for one FIFO direction: one write port, one registered read port.
// Assumes a single clock; read data appear one edge after the address.
module hfx_mem #(
   parameter int DEPTH = 64,
   parameter int AW    = 6
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             we,
   input  wire logic [AW-1:0]    wrAddr,
   input  wire hfx_pkg::hfx_byte_t wrData,
   input  wire logic [AW-1:0]    rdAddr,
   output      hfx_pkg::hfx_byte_t rdData
);
   import hfx_pkg::*;

   hfx_byte_t store [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         store[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdData <= 8'h00;
      end else begin
         rdData <= store[rdAddr];
      end
   end
endmodule

// ==== logic/hfx_frame_fifo.sv ====
// Frame FIFO transfer logic of one HDLC channel: pools, commands, DMA requests.
// Assumes a classic Wishbone master and a byte-level serial engine on the line side.
//
// Summary of operation
// - Two 32-byte transmit pools, write-enable status
// - Frame starts only on transmit command
// - Pool-ready event while message unfinished
// - End of message closes with CRC, flag
// - FIFO empty after first byte, before end, aborts, flags underrun
// - Transmitter reset aborts frame in progress
// - Back-to-back frames share no idle fill
// - Receiver accepts frames split by one flag
// - DMA sends programmed count plus one
// - DMA request per empty pool, then remainder
// - Pool-full event for unfinished 32-byte block
// - Message-end event when frame completes
// - Frame length and appended status byte
// - Receive request held until last read starts
// - Receive request size rounded to 4/8/16/32
// - No receive request after end until release
// - DMA bit chooses DMA or event transfer
// - DMA mode: message-end after last byte
`include "hfx_regs.svh"

module hfx_frame_fifo #(
   parameter int DEPTH = `HFX_FIFO_DEPTH,
   parameter int POOL  = `HFX_POOL_BYTES
) (
   input  wire logic               clk,
   input  wire logic               rstn,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:2]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output      logic [31:0]        wb_dat_o,
   output      logic               wb_ack_o,
   output      hfx_pkg::hfx_byte_t txData,
   output      logic               txValid,
   input  wire logic               txReady,
   output      logic               txEnd,
   output      logic               txAbort,
   input  wire logic               ctsN,
   input  wire hfx_pkg::hfx_byte_t rxData,
   input  wire logic               rxValid,
   input  wire logic               rxEnd,
   input  wire hfx_pkg::hfx_byte_t rxStat,
   output      logic               rxEnable,
   output      logic               txDmaReq,
   output      logic               rxDmaReq
);
   import hfx_pkg::*;

   localparam int          AW    = $clog2(DEPTH);
   localparam logic [AW:0] POOLC = (AW+1)'(POOL);
   localparam logic [AW:0] FULLC = (AW+1)'(DEPTH);

   function automatic logic [5:0] roundUp(input logic [5:0] n);
      roundUp = (n < 6'd4) ? 6'd4 : (n < 6'd8) ? 6'd8 : (n < 6'd16) ? 6'd16 : 6'd32;
   endfunction

   // -------------------------------------------------------------------------
   // Bus slave decode
   // -------------------------------------------------------------------------
   logic       busy, fifoRd;
   hfx_byte_t  modeReg, cfgOne, txCntLo, cntHi, events, extIrq, rxCntLo, rxStatReg;
   logic [3:0] rxCntHi;
   wire        take   = wb_cyc_i & wb_stb_i & ~busy & ~wb_ack_o;
   wire  [5:0] idx    = wb_adr_i;
   wire        isFifo = ~idx[5];
   wire        wrEn   = take & wb_we_i & wb_sel_i[0];
   wire        rdEn   = take & ~wb_we_i;
   wire  [7:0] wd     = wb_dat_i[7:0];
   wire        cmdWr  = wrEn & (idx == `HFX_IDX_STATUS);
   wire        cTxRst = cmdWr & wd[`HFX_CMD_TX_RESET];
   wire        cEnd   = cmdWr & wd[`HFX_CMD_END_MSG];
   wire        cTx    = cmdWr & (wd[`HFX_CMD_TX_IFRAME] | wd[`HFX_CMD_TX_TRANSP]);
   wire        cRxRst = cmdWr & wd[`HFX_CMD_RX_RESET];
   wire        cRxDone = cmdWr & wd[`HFX_CMD_RX_DONE];
   wire        dmaMode = cntHi[`HFX_HI_DMA];
   wire        powerUp = cfgOne[`HFX_CFG_POWER_UP];
   wire        rxOn    = powerUp & modeReg[`HFX_MODE_RX_ACTIVE];
   wire        rdEvt   = rdEn & (idx == `HFX_IDX_EVENTS);
   wire        rdExt   = rdEn & (idx == `HFX_IDX_EXT_IRQ);

   // -------------------------------------------------------------------------
   // Transmit path
   // -------------------------------------------------------------------------
   hfx_tx_e     txState;
   logic [AW:0] txW, txR;
   logic        fetch, endSeen, txGot, pendPool;
   logic [12:0] dmaLeft;
   logic [5:0]  blkLeft;
   hfx_byte_t   txRd;
   wire         txSend   = txState == HFX_TX_SEND;
   wire [AW:0]  txLevel  = txW - txR;
   wire         txEmpty  = txLevel == '0;
   wire         poolFree = txLevel <= POOLC;
   wire         underrun = txSend & ~fetch & txEmpty & ~txValid & ~endSeen & txGot;
   wire         txFlush  = cTxRst | underrun;
   wire         txPush   = wrEn & isFifo & (txLevel != FULLC) & ~txFlush;
   wire         txPop    = txSend & ~fetch & ~txEmpty & (~txValid | txReady) & ~ctsN;
   wire         endNow   = txSend & endSeen & txEmpty & ~fetch & ~txValid & ~cTxRst;
   wire         txStart  = (txState == HFX_TX_IDLE) & cTx & powerUp;
   wire         dmaArm   = txSend & dmaMode & (dmaLeft != '0) & (blkLeft == '0) & poolFree;
   wire [5:0]   blkSize  = (dmaLeft > 13'd32) ? 6'd32 : dmaLeft[5:0];
   wire [5:0]   next_blkLeft = (txFlush | ~txSend) ? 6'd0 : dmaArm ? blkSize :
                               (txPush & (blkLeft != '0)) ? blkLeft - 6'd1 : blkLeft;
   wire         poolReady = ~dmaMode & ((pendPool & txSend & poolFree) | endNow | cTxRst);

   hfx_mem #(.DEPTH(DEPTH), .AW(AW)) txMem (
      .clk    (clk),
      .rstn   (rstn),
      .we     (txPush),
      .wrAddr (txW[AW-1:0]),
      .wrData (wd),
      .rdAddr (txR[AW-1:0]),
      .rdData (txRd)
   );

   always_ff @(posedge clk) begin
      if (!rstn || txFlush) begin
         txW <= '0;
         txR <= '0;
      end else begin
         txW <= txW + (AW+1)'(txPush);
         txR <= txR + (AW+1)'(txPop);
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || txFlush || endNow) begin
         txState <= HFX_TX_IDLE;
      end else if (txStart) begin
         txState <= HFX_TX_SEND;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || txFlush) begin
         {endSeen, txGot, pendPool} <= 3'b000;
         dmaLeft <= '0;
      end else if (txStart) begin
         endSeen  <= ~dmaMode & cEnd;
         pendPool <= ~dmaMode & ~cEnd;
         txGot    <= 1'b0;
         dmaLeft  <= {1'b0, cntHi[3:0], txCntLo} + 13'd1;
      end else begin
         endSeen  <= endSeen | (txSend & cTx & cEnd & ~dmaMode) |
                     (txPush & dmaMode & (dmaLeft == 13'd1));
         pendPool <= (pendPool & ~poolReady) | (txSend & cTx & ~cEnd & ~dmaMode);
         txGot    <= txGot | txPop;
         dmaLeft  <= dmaLeft - 13'(txPush & dmaMode & (dmaLeft != '0));
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         {fetch, txValid, txEnd, txAbort, txDmaReq} <= 5'b00000;
         blkLeft <= '0;
         txData  <= 8'h00;
      end else begin
         fetch    <= txPop & ~txFlush;
         txValid  <= ~txFlush & (fetch | (txValid & ~txReady));
         txEnd    <= endNow;
         txAbort  <= underrun | (cTxRst & txSend);
         blkLeft  <= next_blkLeft;
         txDmaReq <= next_blkLeft != '0;
         if (fetch) begin
            txData <= txRd;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Receive path
   // -------------------------------------------------------------------------
   logic [AW:0] rxW, rxR, rxBase;
   logic [5:0]  segCnt, offerLen, p2Len, rxDmaLeft;
   logic        offerValid, offerEnd, p2Valid, p2End, ovfl;
   logic [11:0] rxLen;
   hfx_byte_t   rxRd;
   wire         rxIn      = rxOn & (rxValid | rxEnd);
   wire         release_  = cRxDone & offerValid;
   wire         qFull     = offerValid & p2Valid & ~release_;
   wire         rxDrop    = rxIn & (((rxW - rxBase) == FULLC) | qFull);
   wire         rxWe      = rxIn & ~rxDrop & ~cRxRst;
   wire [7:0]   statByte  = rxStat | (8'h01 << `HFX_RXSTAT_OVFL) & {8{ovfl}};
   wire         blockDone = rxWe & (rxEnd | (segCnt == 6'(POOL - 1)));
   wire [5:0]   doneLen   = segCnt + 6'd1;
   wire         toOffer   = blockDone & (~offerValid | (release_ & ~p2Valid));
   wire         newOffer  = toOffer | (release_ & p2Valid);
   wire [5:0]   nextLen   = (release_ & p2Valid) ? p2Len : doneLen;
   wire         nextEnd   = (release_ & p2Valid) ? p2End : rxEnd;
   wire         rxRead    = rdEn & isFifo;
   wire [5:0]   next_rxDmaLeft = (cRxRst | ~dmaMode) ? 6'd0 :
                                 newOffer ? roundUp(nextLen) :
                                 release_ ? 6'd0 :
                                 (rxRead & (rxDmaLeft != '0)) ? rxDmaLeft - 6'd1 : rxDmaLeft;
   wire         lastDma   = dmaMode & offerEnd & rxRead & (rxDmaLeft == 6'd1) & ~newOffer;

   hfx_mem #(.DEPTH(DEPTH), .AW(AW)) rxMem (
      .clk    (clk),
      .rstn   (rstn),
      .we     (rxWe),
      .wrAddr (rxW[AW-1:0]),
      .wrData (rxEnd ? statByte : rxData),
      .rdAddr (rxR[AW-1:0]),
      .rdData (rxRd)
   );

   always_ff @(posedge clk) begin
      if (!rstn || cRxRst) begin
         {rxW, rxR, rxBase} <= '0;
         {segCnt, rxLen, ovfl} <= '0;
      end else begin
         rxW    <= rxW + (AW+1)'(rxWe);
         segCnt <= blockDone ? 6'd0 : segCnt + 6'(rxWe);
         rxLen  <= (rxWe & rxEnd) ? 12'd0 : rxLen + 12'(rxWe);
         ovfl   <= rxWe & rxEnd ? 1'b0 : ovfl | rxDrop;
         if (release_) begin
            rxBase <= rxBase + (AW+1)'(offerLen);
            rxR    <= rxBase + (AW+1)'(offerLen);
         end else begin
            rxR <= rxR + (AW+1)'(rxRead);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || cRxRst) begin
         {offerValid, offerEnd, p2Valid, p2End} <= 4'b0000;
         {offerLen, p2Len} <= '0;
      end else begin
         if (release_) begin
            p2Valid <= 1'b0;
         end
         if (newOffer) begin
            offerValid <= 1'b1;
            offerLen   <= nextLen;
            offerEnd   <= nextEnd;
         end else if (release_) begin
            offerValid <= 1'b0;
         end
         if (blockDone & ~toOffer) begin
            p2Valid <= 1'b1;
            p2Len   <= doneLen;
            p2End   <= rxEnd;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rxDmaLeft <= '0;
         rxDmaReq  <= 1'b0;
         rxEnable  <= 1'b0;
         {rxCntLo, rxStatReg} <= '0;
         rxCntHi   <= '0;
      end else begin
         rxDmaLeft <= next_rxDmaLeft;
         rxDmaReq  <= next_rxDmaLeft != '0;
         rxEnable  <= rxOn;
         if (rxWe & rxEnd) begin
            {rxCntHi, rxCntLo} <= rxLen + 12'd1;
            rxStatReg <= statByte;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Registers and bus answer
   // -------------------------------------------------------------------------
   wire [7:0] evtSet = (8'(poolReady) << `HFX_EVT_POOL_READY) |
                       (8'(newOffer & ~nextEnd & ~dmaMode) << `HFX_EVT_POOL_FULL) |
                       (8'((newOffer & nextEnd & ~dmaMode) | lastDma) << `HFX_EVT_MSG_END);
   wire [7:0] stsVal = (8'(poolFree) << `HFX_STS_TX_WR_EN) |
                       (8'(!rxOn) << `HFX_STS_RX_IDLE) | (8'(txSend) << `HFX_STS_TX_BUSY);
   wire [7:0] regMux = (idx == `HFX_IDX_EVENTS)    ? events :
                       (idx == `HFX_IDX_STATUS)    ? stsVal :
                       (idx == `HFX_IDX_MODE)      ? modeReg :
                       (idx == `HFX_IDX_EXT_IRQ)   ? extIrq :
                       (idx == `HFX_IDX_RX_CNT_LO) ? rxCntLo :
                       (idx == `HFX_IDX_RX_STAT)   ? rxStatReg :
                       (idx == `HFX_IDX_CNT_HI)    ? {cntHi[7:4], rxCntHi} :
                       (idx == `HFX_IDX_CFG_ONE)   ? cfgOne : 8'h00;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         {modeReg, cfgOne, txCntLo, cntHi, events, extIrq} <= {6{`HFX_RST_BYTE}};
      end else begin
         events <= (events & ~{8{rdEvt}}) | evtSet;
         extIrq <= (extIrq & ~{8{rdExt}}) | (8'(underrun) << `HFX_EXT_UNDERRUN);
         if (wrEn & (idx == `HFX_IDX_MODE))      modeReg <= wd;
         if (wrEn & (idx == `HFX_IDX_CFG_ONE))   cfgOne  <= wd;
         if (wrEn & (idx == `HFX_IDX_TX_CNT_LO)) txCntLo <= wd;
         if (wrEn & (idx == `HFX_IDX_CNT_HI))    cntHi   <= wd;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         {busy, wb_ack_o, fifoRd} <= 3'b000;
         wb_dat_o <= '0;
      end else begin
         busy     <= take;
         wb_ack_o <= busy;
         fifoRd   <= rxRead;
         if (take) begin
            wb_dat_o <= {24'h0, regMux};
         end else if (busy & fifoRd) begin
            wb_dat_o <= {24'h0, rxRd};
         end
      end
   end

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   property p_txStart;
      @(posedge clk) disable iff (!rstn) $rose(txSend) |-> $past(cTx && powerUp);
   endproperty
   a_txStart: assert property (p_txStart) else $error("frame began without command");

   property p_underrun;
      @(posedge clk) disable iff (!rstn)
         underrun |=> txAbort && extIrq[`HFX_EXT_UNDERRUN] && !txSend ##1 !txAbort;
   endproperty
   a_underrun: assert property (p_underrun) else $error("underrun not aborted");

   property p_txReset;
      @(posedge clk) disable iff (!rstn) (cTxRst && txSend) |=> txAbort && !txValid && !txSend;
   endproperty
   a_txReset: assert property (p_txReset) else $error("reset did not abort frame");

   property p_txCount;
      @(posedge clk) disable iff (!rstn)
         (txStart && dmaMode) |=> dmaLeft == $past({1'b0, cntHi[3:0], txCntLo}) + 13'd1;
   endproperty
   a_txCount: assert property (p_txCount) else $error("DMA byte count wrong");

   property p_txReqLen;
      @(posedge clk) disable iff (!rstn) $rose(txDmaReq) |-> blkLeft <= 6'd32 && txSend;
   endproperty
   a_txReqLen: assert property (p_txReqLen) else $error("transmit request outside frame");

   property p_rxDrop;
      @(posedge clk) disable iff (!rstn)
         (rxRead && rxDmaLeft == 6'd1 && !newOffer && !cRxRst) |=> !rxDmaReq;
   endproperty
   a_rxDrop: assert property (p_rxDrop) else $error("receive request held too long");

   property p_round;
      @(posedge clk) disable iff (!rstn)
         (newOffer && dmaMode && !cRxRst) |=> rxDmaReq && rxDmaLeft >= offerLen &&
            (rxDmaLeft == 6'd4 || rxDmaLeft == 6'd8 || rxDmaLeft == 6'd16 || rxDmaLeft == 6'd32);
   endproperty
   a_round: assert property (p_round) else $error("receive request size not rounded");

   property p_holdOff;
      @(posedge clk) disable iff (!rstn)
         (offerValid && offerEnd && rxDmaLeft == 6'd0 && !cRxDone) |=> !rxDmaReq;
   endproperty
   a_holdOff: assert property (p_holdOff) else $error("request before release");

   property p_status;
      @(posedge clk) disable iff (!rstn)
         (rxWe && rxEnd) |=> rxStatReg == $past(statByte) && {rxCntHi, rxCntLo} != 12'd0;
   endproperty
   a_status: assert property (p_status) else $error("frame status not held");
endmodule

// ==== sim/hfx_line_model.sv ====
// Serial engine model on the line side of the frame FIFO block.
// Assumes the bench clock; the bench calls send() to deliver frames.
module hfx_line_model (
   input  wire logic               clk,
   input  wire logic               rstn,
   input  wire logic               slow,
   input  wire logic               hold,
   input  wire hfx_pkg::hfx_byte_t txData,
   input  wire logic               txValid,
   output      logic               txReady = 1'b0,
   input  wire logic               txEnd,
   input  wire logic               txAbort,
   output      hfx_pkg::hfx_byte_t rxData = 8'h00,
   output      logic               rxValid = 1'b0,
   output      logic               rxEnd = 1'b0,
   output      hfx_pkg::hfx_byte_t rxStat = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   import hfx_pkg::*;
   hfx_byte_t  txQ[$];
   int         ends = 0;
   int         aborts = 0;
   logic [1:0] tick = 2'h0;
   // Slow mode takes one byte in four cycles; hold takes none
   always @(posedge clk) begin
      tick <= tick + 2'h1;
      txReady <= rstn && !hold && (!slow || tick == 2'h0);
      if (txValid && txReady) txQ.push_back(txData);
      if (txEnd) ends++;
      if (txAbort) aborts++;
   end
   // Idle lines show the inverse of the last value
   task automatic send(input hfx_byte_t b[$], input hfx_byte_t st);
      foreach (b[i]) begin
         @(posedge clk);
         rxValid <= 1'b1;
         rxData <= b[i];
         @(posedge clk);
         rxValid <= 1'b0;
         rxData <= ~b[i];
      end
      @(posedge clk);
      rxEnd <= 1'b1;
      rxStat <= st;
      @(posedge clk);
      rxEnd <= 1'b0;
      rxStat <= ~st;
   endtask
endmodule

// ==== sim/tb.sv ====
// Self-checking bench of the frame FIFO block.
// Assumes the line model beside it and a classic Wishbone master here.
`include "hfx_regs.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import hfx_pkg::*;
   localparam logic [5:0] ST = `HFX_IDX_STATUS;
   localparam logic [5:0] EV = `HFX_IDX_EVENTS;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic        slow = 1'b0;
   logic        hold = 1'b0;
   logic        reqLast = 1'b0;
   logic [5:0]  adr = 6'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        ack, txValid, txReady, txEnd, txAbort, rxValid, rxEnd;
   logic        rxEnable, txDmaReq, rxDmaReq;
   hfx_byte_t   txData, rxData, rxStat, q, b, st;
   hfx_byte_t   exp[$];
   int          blk[$];
   int          err_count = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   int          seed = 32'h019e;
   int          k;
   int          mark;
   int          falls = 0;
   int          lens[7] = '{1, 3, 4, 7, 8, 15, 31};

   hfx_frame_fifo i_hfx_frame_fifo (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .txData(txData), .txValid(txValid), .txReady(txReady), .txEnd(txEnd),
      .txAbort(txAbort), .ctsN(1'b0), .rxData(rxData), .rxValid(rxValid), .rxEnd(rxEnd),
      .rxStat(rxStat), .rxEnable(rxEnable), .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq));
   hfx_line_model i_hfx_line_model (.clk(clk), .rstn(rstn), .slow(slow), .hold(hold),
      .txData(txData), .txValid(txValid), .txReady(txReady), .txEnd(txEnd), .txAbort(txAbort),
      .rxData(rxData), .rxValid(rxValid), .rxEnd(rxEnd), .rxStat(rxStat));

   // ----------------------------------------------------------------------
   // Bench tasks
   // ----------------------------------------------------------------------
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want, input string m);
      cmp_count++;
      if (got !== want) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic wb(input logic w, input logic [5:0] a, input hfx_byte_t d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // Any index below 0x20 reaches the FIFO
   task automatic put(input int n);
      repeat (n) begin
         b = 8'($random(seed));
         exp.push_back(b);
         wb(1'b1, 6'($random(seed)) & 6'h1f, b);
      end
   endtask
   task automatic getq(input int lo, input int hi);
      for (int i = lo; i < hi; i++) begin
         wb(1'b0, 6'($random(seed)) & 6'h1f, 8'h00);
         chk(q, exp[i], "rx byte");
      end
   endtask
   task automatic txcmp(input int n);
      chk(i_hfx_line_model.txQ.size(), n, "tx length");
      foreach (exp[i]) chk(i_hfx_line_model.txQ[i], exp[i], "tx byte");
      i_hfx_line_model.txQ.delete();
   endtask
   function automatic int roundup(input int n);
      return n <= 3 ? 4 : n <= 7 ? 8 : n <= 15 ? 16 : 32;
   endfunction

   initial forever #5 clk = ~clk;
   // Counts falls of the transmit request, which may dip for one cycle only
   always @(posedge clk) begin
      reqLast <= txDmaReq;
      if (reqLast === 1'b1 && txDmaReq === 1'b0) falls++;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      wb(1'b0, ST, 8'h00);
      chk(q, 8'h48, "status after reset");
      wb(1'b0, `HFX_IDX_CFG_ONE, 8'h00);
      chk(q, `HFX_RST_BYTE, "config after reset");
      wb(1'b0, 6'h23, 8'h00);
      chk(q, 8'h00, "unmapped read");
      wb(1'b1, `HFX_IDX_CFG_ONE, 8'h80);
      wb(1'b1, ST, 8'h41);
      wb(1'b1, `HFX_IDX_MODE, 8'h08);
      @(posedge clk);
      chk(rxEnable, 1'b1, "receiver enable");
      $display("bring-up test done");
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         exp.delete();
         put(1 + ($random(seed) & 31));
         wb(1'b0, ST, 8'h00);
         chk(q[6], 1'b1, "write enable");
         chk(i_hfx_line_model.txQ.size(), 0, "sent before command");
         k = i_hfx_line_model.ends;
         wb(1'b1, ST, 8'h0a);
         while (i_hfx_line_model.ends == k) @(posedge clk);
         txcmp(exp.size());
         wb(1'b0, EV, 8'h00);
         chk(q[4], 1'b1, "pool ready");
      end
      exp.delete();
      put(2);
      k = i_hfx_line_model.aborts;
      wb(1'b1, ST, 8'h08);
      while (i_hfx_line_model.aborts == k) @(posedge clk);
      wb(1'b0, `HFX_IDX_EXT_IRQ, 8'h00);
      chk(q[6], 1'b1, "underrun flag");
      put(3);
      k = i_hfx_line_model.aborts;
      wb(1'b1, ST, 8'h08);
      wb(1'b1, ST, 8'h01);
      repeat (10) @(posedge clk);
      chk(i_hfx_line_model.aborts, k + 1, "reset abort");
      i_hfx_line_model.txQ.delete();
      slow <= 1'b0;
      $display("transmit test done");
      exp.delete();
      repeat (40) exp.push_back(8'($random(seed)));
      st = 8'($random(seed)) & 8'hdf;
      i_hfx_line_model.send(exp, st);
      exp.push_back(st);
      wb(1'b0, EV, 8'h00);
      b = q;
      chk(b[6], 1'b1, "pool full");
      getq(0, 32);
      wb(1'b1, ST, 8'h80);
      wb(1'b0, EV, 8'h00);
      b = b | q;
      chk(b[7], 1'b1, "message end");
      wb(1'b0, `HFX_IDX_RX_CNT_LO, 8'h00);
      chk(q, 8'd41, "rx length");
      wb(1'b0, `HFX_IDX_RX_STAT, 8'h00);
      chk(q, st, "rx status");
      getq(32, 41);
      wb(1'b1, ST, 8'h80);
      $display("receive test done");
      wb(1'b1, `HFX_IDX_TX_CNT_LO, 8'h27);
      wb(1'b1, `HFX_IDX_CNT_HI, 8'h80);
      k = i_hfx_line_model.ends;
      exp.delete();
      // Line stalls while the bus fills, so the frame cannot run dry
      hold <= 1'b1;
      wb(1'b1, ST, 8'h08);
      while (exp.size() < 40) begin
         while (txDmaReq !== 1'b1) @(posedge clk);
         blk.push_back(exp.size());
         mark = falls;
         while (falls == mark) put(1);
         blk[$] = exp.size() - blk[$];
      end
      hold <= 1'b0;
      while (i_hfx_line_model.ends == k) @(posedge clk);
      chk(blk[0], 32, "first block");
      chk(blk[1], 8, "remainder block");
      txcmp(40);
      foreach (lens[i]) begin
         exp.delete();
         repeat (lens[i]) exp.push_back(8'($random(seed)));
         st = 8'($random(seed)) & 8'hdf;
         i_hfx_line_model.send(exp, st);
         exp.push_back(st);
         if (i > 0) begin
            repeat (4) @(posedge clk);
            chk(rxDmaReq, 1'b0, "request before release");
            wb(1'b1, ST, 8'h80);
         end
         while (rxDmaReq !== 1'b1) @(posedge clk);
         k = 0;
         while (rxDmaReq === 1'b1) begin
            wb(1'b0, 6'h00, 8'h00);
            if (k <= lens[i]) chk(q, exp[k], "dma rx byte");
            k++;
         end
         chk(k, roundup(lens[i] + 1), "request size");
         wb(1'b0, EV, 8'h00);
         chk(q[7], 1'b1, "dma message end");
      end
      wb(1'b1, ST, 8'h80);
      $display("dma test done");
      stop_test();
   end
endmodule
